/* File: hw/sar_adc_regs.svh */
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// ==========================================================================
// result and channel geometry
`define SAR_RES_BITS      12
`define SAR_NUM_CHAN      8
`define SAR_CHAN_BITS     3
`define SAR_MODE_SINGLE   1'b1

// ==========================================================================
// serial clock positions, counted from the start-bit clock (index 0)
`define SAR_IDX_MODE      5'd1
`define SAR_IDX_SEL_FIRST 5'd2
`define SAR_IDX_SEL_LAST  5'd4
`define SAR_IDX_SAMP_BEG  5'd4
`define SAR_IDX_SAMP_END  5'd5
`define SAR_IDX_NULL      5'd6
`define SAR_IDX_MSB_FIRST 5'd7
`define SAR_IDX_MSB_LAST  5'd18
`define SAR_IDX_LSB_LAST  5'd29
`define SAR_IDX_MAX       5'd31

`endif

/* File: hw/sar_pkg.sv */
`default_nettype none

package sar_pkg;
    typedef enum logic [1:0] {
        ST_STANDBY    = 2'b00,
        ST_WAIT_START = 2'b01,
        ST_ACTIVE     = 2'b10
    } sar_state_e;

    typedef logic [11:0] sar_code_t;
    typedef logic [2:0]  sar_chan_t;
    typedef logic [4:0]  sar_idx_t;
endpackage

`default_nettype wire

/* File: hw/sar_adc_serial.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.svh"

module sar_adc_serial (
    // clock and reset
    input  wire logic                       CLOCK,
    input  wire logic                       SYS_RST,
    // serial pins
    input  wire logic                       CHIP_SELECT_SHUTDOWN_N,
    input  wire logic                       SCLK,
    input  wire logic                       DIN,
    output logic                            DOUT,
    output logic                            DOUT_OE_N,
    // digitised analog inputs, channel k in bits [12k+11:12k]
    input  wire logic [95:0]                ANALOG_INPUTS,
    // variant strap
    input  wire logic                       FOUR_CHANNEL,
    // status
    output logic                            SAMPLE_ACTIVE,
    output logic                            BIAS_ENABLE,
    output logic                            STANDBY,
    output logic                            INPUT_MODE_SELECT,
    output sar_pkg::sar_chan_t              CHAN_POS,
    output sar_pkg::sar_chan_t              CHAN_NEG
);
    import sar_pkg::*;

    // ======================================================================
    // pin synchronisers
    logic       cs_n_s1_q, cs_n_s2_q;
    logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic       din_s1_q, din_s2_q;
    logic       four_s1_q, four_s2_q;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            // reset low: a pin held low since power-up must not arm
            cs_n_s1_q <= 1'b0;
            cs_n_s2_q <= 1'b0;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            din_s1_q  <= 1'b0;
            din_s2_q  <= 1'b0;
            four_s1_q <= 1'b0;
            four_s2_q <= 1'b0;
        end else begin
            cs_n_s1_q <= CHIP_SELECT_SHUTDOWN_N;
            cs_n_s2_q <= cs_n_s1_q;
            sclk_s1_q <= SCLK;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            din_s1_q  <= DIN;
            din_s2_q  <= din_s1_q;
            four_s1_q <= FOUR_CHANNEL;
            four_s2_q <= four_s1_q;
        end
    end

    // serial clock must stay well below a quarter of CLOCK to be seen
    wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
    wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
    wire cs_low    = ~cs_n_s2_q;

    // ======================================================================
    // state and command registers
    sar_state_e state_q, state_d;
    sar_idx_t   idx_q;
    logic       armed_q;
    logic       mode_q;
    sar_chan_t  sel_q;
    sar_code_t  result_q;
    logic       dout_q, dout_oe_n_q;
    logic       sample_q, bias_q;
    sar_chan_t  chan_pos_q, chan_neg_q;
    logic       standby_q;

    // ======================================================================
    // decode
    wire        in_active  = (state_q == ST_ACTIVE) & cs_low;
    wire        start_seen = (state_q == ST_WAIT_START) & cs_low & sclk_rise & din_s2_q;
    wire        act_rise   = in_active & sclk_rise;
    wire        act_fall   = in_active & sclk_fall;
    wire [4:0]  idx_next   = (idx_q == `SAR_IDX_MAX) ? idx_q : idx_q + 5'd1;

    // variant masks the top select bit in both modes
    wire [2:0]  sel_eff    = {sel_q[2] & ~four_s2_q, sel_q[1:0]};
    wire [2:0]  pair_base  = {sel_eff[2:1], 1'b0};
    wire [2:0]  pos_chan   = (mode_q == `SAR_MODE_SINGLE) ? sel_eff
                           : (pair_base | {2'b00, sel_eff[0]});
    wire [2:0]  neg_chan   = pair_base | {2'b00, ~sel_eff[0]};

    // ======================================================================
    // input codes; each channel already holds floor(4096*vin/vref)
    logic [11:0] chan_code [`SAR_NUM_CHAN];
    genvar g;
    generate
        for (g = 0; g < `SAR_NUM_CHAN; g++) begin : g_chan
            assign chan_code[g] = ANALOG_INPUTS[g*`SAR_RES_BITS +: `SAR_RES_BITS];
        end
    endgenerate

    wire [11:0] pos_code  = chan_code[pos_chan];
    wire [11:0] neg_code  = chan_code[neg_chan];
    wire        diff_zero = (pos_code <= neg_code);
    wire [11:0] diff_code = diff_zero ? 12'h000 : pos_code - neg_code;
    wire [11:0] conv_code = (mode_q == `SAR_MODE_SINGLE) ? pos_code : diff_code;

    // ======================================================================
    // output bit selection by falling-edge position
    wire [3:0]  msb_bit   = 4'(`SAR_IDX_MSB_LAST - idx_q);
    wire [3:0]  lsb_bit   = 4'(idx_q - `SAR_IDX_MSB_LAST);
    wire        in_msb    = (idx_q >= `SAR_IDX_MSB_FIRST) & (idx_q <= `SAR_IDX_MSB_LAST);
    wire        in_lsb    = (idx_q > `SAR_IDX_MSB_LAST) & (idx_q <= `SAR_IDX_LSB_LAST);
    wire        next_bit  = in_msb ? result_q[msb_bit]
                          : in_lsb ? result_q[lsb_bit]
                          : 1'b0;
    wire        drive_now = (idx_q >= `SAR_IDX_NULL);

    // ======================================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_STANDBY: begin
                if (cs_low & armed_q) begin
                    state_d = ST_WAIT_START;
                end
            end
            ST_WAIT_START: begin
                if (!cs_low) begin
                    state_d = ST_STANDBY;
                end else if (start_seen) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!cs_low) begin
                    state_d = ST_STANDBY;
                end
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_q <= ST_STANDBY;
            armed_q <= 1'b0;
            standby_q <= 1'b1;
        end else begin
            state_q <= state_d;
            standby_q <= (state_d == ST_STANDBY);
            if (!cs_low) begin
                armed_q <= 1'b1;
            end
        end
    end

    // command capture on rising edges; zeros before start leave it idle
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            idx_q  <= 5'd0;
            mode_q <= 1'b0;
            sel_q  <= 3'd0;
        end else if (start_seen) begin
            idx_q  <= 5'd0;
            mode_q <= 1'b0;
            sel_q  <= 3'd0;
        end else if (act_rise) begin
            idx_q <= idx_next;
            if (idx_next == `SAR_IDX_MODE) begin
                mode_q <= din_s2_q;
            end
            if (idx_next >= `SAR_IDX_SEL_FIRST && idx_next <= `SAR_IDX_SEL_LAST) begin
                sel_q <= {sel_q[1:0], din_s2_q};
            end
        end
    end

    // acquisition window, conversion capture and power control
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            sample_q   <= 1'b0;
            bias_q     <= 1'b0;
            result_q   <= 12'h000;
            chan_pos_q <= 3'd0;
            chan_neg_q <= 3'd0;
        end else if (!in_active) begin
            sample_q <= 1'b0;
            bias_q   <= 1'b0;
        end else if (act_rise && idx_next == `SAR_IDX_SAMP_BEG) begin
            sample_q <= 1'b1;
            bias_q   <= 1'b1;
        end else if (act_fall && idx_q == `SAR_IDX_SAMP_END) begin
            // held value is what the bit-per-clock conversion would settle to
            sample_q   <= 1'b0;
            result_q   <= conv_code;
            chan_pos_q <= pos_chan;
            chan_neg_q <= neg_chan;
        end else if (act_fall && idx_q == `SAR_IDX_MSB_LAST) begin
            bias_q <= 1'b0;
        end
    end

    // serial output changes only on falling edges or on leaving active; zeroed and released outside active
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            dout_q      <= 1'b0;
            dout_oe_n_q <= 1'b1;
        end else if (!in_active) begin
            dout_q      <= 1'b0;
            dout_oe_n_q <= 1'b1;
        end else if (act_fall && drive_now) begin
            dout_q      <= next_bit;
            dout_oe_n_q <= 1'b0;
        end
    end

    assign DOUT              = dout_q;
    assign DOUT_OE_N         = dout_oe_n_q;
    assign SAMPLE_ACTIVE     = sample_q;
    assign BIAS_ENABLE       = bias_q;
    assign STANDBY           = standby_q;
    assign INPUT_MODE_SELECT = mode_q;
    assign CHAN_POS          = chan_pos_q;
    assign CHAN_NEG          = chan_neg_q;

    // ======================================================================
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_cs_high_hiz: assert property (!cs_low |=> dout_oe_n_q && !sample_q)
        else $error("output driven or sampling with select high");
    a_arm_first: assert property (!armed_q |-> state_q != ST_ACTIVE)
        else $error("transaction accepted before select was raised");
    a_start_bit: assert property (start_seen |=> state_q == ST_ACTIVE && idx_q == 5'd0)
        else $error("start bit not taken");
    a_lead_zeros: assert property ((state_q == ST_WAIT_START) && cs_low && sclk_rise
                                   && !din_s2_q |=> state_q == ST_WAIT_START)
        else $error("leading zero taken as start");
    a_mode_bit: assert property (act_rise && idx_q == 5'd0 |=> mode_q == $past(din_s2_q))
        else $error("mode bit not captured");
    a_fresh_cfg: assert property (start_seen |=> mode_q == 1'b0 && sel_q == 3'd0)
        else $error("configuration carried over");
    a_dont_care: assert property (act_rise && idx_q == 5'd4 |=> $stable(sel_q))
        else $error("select changed during extra clock");
    a_samp_start: assert property (act_rise && idx_q == 5'd3 |=> sample_q && bias_q)
        else $error("sampling did not start");
    a_samp_end: assert property (act_fall && idx_q == 5'd5 |=> !sample_q)
        else $error("sampling did not end");
    a_null_bit: assert property (act_fall && idx_q == 5'd6 |=> !dout_q && !dout_oe_n_q)
        else $error("null bit missing");
    a_msb_first: assert property (act_fall && idx_q == 5'd7 |=> dout_q == result_q[11])
        else $error("first result bit is not msb");
    a_lsb_first: assert property (act_fall && idx_q == 5'd19 |=> dout_q == result_q[1])
        else $error("lsb-first repeat wrong");
    a_zero_tail: assert property (act_fall && idx_q >= 5'd30 |=> !dout_q)
        else $error("tail not zero");
    a_fall_only: assert property ($changed(dout_q) |-> $past(sclk_fall) || $past(!cs_low))
        else $error("output changed off a falling edge");
    a_bias_off: assert property (act_fall && idx_q == 5'd18 |=> !bias_q ##1 !bias_q)
        else $error("bias still on in readout");
    a_four_mask: assert property (four_s2_q |-> !sel_eff[2])
        else $error("top select bit used on small variant");
    a_diff_clamp: assert property (act_fall && idx_q == 5'd5 && !mode_q && diff_zero
                                   |=> result_q == 12'h000)
        else $error("differential result not clamped");

    // transaction-level checks
    a_cs_abort: assert property ($fell(cs_low) |=> state_q == ST_STANDBY && standby_q)
        else $error("select high did not abort to standby");
    a_idle_high: assert property (standby_q && !cs_low |=> state_q == ST_STANDBY)
        else $error("traffic taken with select high");
    a_standby_hiz: assert property (standby_q |-> dout_oe_n_q)
        else $error("output driven in standby");
    a_oe_pre_null: assert property (state_q == ST_ACTIVE && idx_q < 5'd6 |-> dout_oe_n_q)
        else $error("output driven before null bit");
    a_null_only: assert property ($fell(dout_oe_n_q) |-> idx_q == 5'd6)
        else $error("output enabled away from null bit");
    a_sel_shift: assert property (act_rise && idx_q >= 5'd1 && idx_q <= 5'd3
                                  |=> sel_q == {$past(sel_q[1:0]), $past(din_s2_q)})
        else $error("select bit not shifted in");
    a_late_din: assert property (act_rise && idx_q >= 5'd4
                                 |=> $stable(sel_q) && $stable(mode_q))
        else $error("data input used after select bits");
    a_samp_idx: assert property ($rose(sample_q) |-> idx_q == 5'd4)
        else $error("sampling began at wrong clock");
    a_bias_held: assert property (in_active && idx_q >= 5'd4 && idx_q <= 5'd17 |-> bias_q)
        else $error("bias dropped during conversion");
    a_single_chan: assert property (act_fall && idx_q == 5'd5 && mode_q && !four_s2_q
                                    |=> chan_pos_q == $past(sel_q))
        else $error("single-ended channel wrong");
    a_four_chan: assert property (act_fall && idx_q == 5'd5 && four_s2_q
                                  |=> !chan_pos_q[2] && !chan_neg_q[2])
        else $error("small variant used an upper channel");
    a_diff_pair: assert property (act_fall && idx_q == 5'd5 && !mode_q
                                  |=> chan_pos_q[2:1] == chan_neg_q[2:1])
        else $error("differential inputs not an adjacent pair");
    a_diff_pol: assert property (act_fall && idx_q == 5'd5 && !mode_q
                                 |=> chan_pos_q[0] == $past(sel_q[0])
                                     && chan_neg_q[0] != chan_pos_q[0])
        else $error("differential polarity wrong");
    a_result_hold: assert property (state_q == ST_ACTIVE && idx_q >= 5'd6
                                    |-> $stable(result_q))
        else $error("result changed during readout");
    a_msb_last: assert property (act_fall && idx_q == 5'd18 |=> dout_q == result_q[0])
        else $error("last msb-first bit wrong");
    a_lsb_mid: assert property (act_fall && idx_q == 5'd24 |=> dout_q == result_q[6])
        else $error("lsb-first middle bit wrong");
    a_lsb_last: assert property (act_fall && idx_q == 5'd29 |=> dout_q == result_q[11])
        else $error("lsb-first last bit wrong");

    c_start:    cover property (start_seen);
    c_null:     cover property (act_fall && idx_q == 5'd6);
    c_lsb_tail: cover property (act_fall && idx_q == 5'd30);
    c_diff:     cover property (act_fall && idx_q == 5'd5 && !mode_q);
    c_single:   cover property (act_fall && idx_q == 5'd5 && mode_q && four_s2_q);

endmodule

`default_nettype wire

/* File: tb/sar_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// host serial master, clock idles low
module sar_host_model (
    // clock
    input  wire logic        clk,
    // serial pins
    output logic             chip_select_shutdown_n,
    output logic             sclk,
    output logic             din,
    input  wire logic        dout,
    input  wire logic        dout_oe_n,
    // status taps
    input  wire logic        sample_active,
    input  wire logic        bias_enable,
    // captured frame
    output logic [32:0]      rx_word,
    output logic             rx_done,
    output logic             oe_any
);
    // six system clocks per half keeps sclk well under the sync limit
    localparam int HALF = 6;
    logic line;

    initial begin
        chip_select_shutdown_n = 1'b0;
        sclk = 1'b0;
        din = 1'b0;
        rx_word = '0;
        rx_done = 1'b0;
        oe_any = 1'b0;
        line = 1'b0;
    end

    task automatic frame(input int lead, input logic [4:0] cmd, input int n,
                         input logic level, input logic rep);
        int j;
        logic [4:0] st;
        logic [27:0] w;
        st = '0;
        w = '0;
        repeat (HALF) @(posedge clk);
        chip_select_shutdown_n <= level;
        oe_any = 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < lead + n; i++) begin
            j = i - lead;
            din <= (j < 0) ? 1'b0 : (j < 5) ? cmd[4 - j] : ~din;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            // a released line shows no stale value
            line = dout_oe_n ? ~line : dout;
            oe_any = oe_any | ~dout_oe_n;
            if (j == 5) st[4] = sample_active;
            if (j == 6) st[3] = dout_oe_n;
            if (j == 7) st[2] = sample_active;
            if (j == 8) st[1] = bias_enable;
            if (j == 20) st[0] = bias_enable;
            if (j >= 7 && j <= 34) w = {w[26:0], line};
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        chip_select_shutdown_n <= 1'b1;
        rx_word <= {st, w};
        rx_done <= rep;
        @(posedge clk);
        rx_done <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sar_pkg::*;
    typedef struct {logic [32:0] w; sar_chan_t p; sar_chan_t n; logic m;} sar_exp_s;

    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        four = 1'b0;
    logic [95:0] ana = '0;
    logic [31:0] seed = 32'h1f356b4e;
    logic        dout_prev = 1'b0;
    int          fail_count = 0;
    int          checks_done = 0;
    sar_exp_s    q[$];
    sar_exp_s    mon_e;
    wire logic cs_n, sclk, din, dout, oe_n, sa, bias, stby, mode, done, oe_any;
    wire logic [32:0] rx_word;
    wire sar_chan_t   cpos, cneg;

    always #25 clock = ~clock;

    sar_adc_serial uut (.CLOCK(clock), .SYS_RST(sys_rst), .CHIP_SELECT_SHUTDOWN_N(cs_n),
        .SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_OE_N(oe_n), .ANALOG_INPUTS(ana),
        .FOUR_CHANNEL(four), .SAMPLE_ACTIVE(sa), .BIAS_ENABLE(bias), .STANDBY(stby),
        .INPUT_MODE_SELECT(mode), .CHAN_POS(cpos), .CHAN_NEG(cneg));
    sar_host_model host (.clk(clock), .chip_select_shutdown_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe_n(oe_n), .sample_active(sa), .bias_enable(bias),
        .rx_word(rx_word), .rx_done(done), .oe_any(oe_any));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic run(input logic m, input logic [2:0] s, input logic fc, input int lead);
        sar_exp_s  e;
        sar_chan_t b;
        sar_code_t pc;
        sar_code_t nc;
        sar_code_t c;
        @(posedge clock);
        four <= fc;
        for (int k = 0; k < 3; k++) begin
            seed = xorshift(seed);
            ana[k*32 +: 32] <= seed;
        end
        @(posedge clock);
        b = fc ? {1'b0, s[1:0]} : s;
        e.p = m ? b : {b[2:1], s[0]};
        e.n = {b[2:1], ~s[0]};
        pc = ana[e.p*12 +: 12];
        nc = ana[e.n*12 +: 12];
        c = m ? pc : ((pc > nc) ? pc - nc : 12'h000);
        e.w = {5'h1a, 1'b0, c, 15'h0};
        for (int k = 0; k < 11; k++) e.w[14 - k] = c[k + 1];
        e.m = m;
        q.push_back(e);
        host.frame(lead, {1'b1, m, s}, 36, 1'b0, 1'b1);
    endtask

    // result bits, null bit, zeros, sampling and bias taps
    always @(posedge clock) begin
        if (done === 1'b1) begin
            mon_e = q.pop_front();
            check(rx_word, mon_e.w);
            check(cpos, mon_e.p);
            check(mode, mon_e.m);
            if (!mon_e.m) check(cneg, mon_e.n);
        end
        if (sclk === 1'b1) check(dout, dout_prev);
        dout_prev <= dout;
    end

    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        // select low since power-up: not yet armed
        host.frame(0, 5'h18, 36, 1'b0, 1'b0);
        check(oe_any, 1'b0);
        host.frame(0, 5'h18, 36, 1'b1, 1'b0);
        check(oe_any, 1'b0);
        host.frame(2, 5'h16, 14, 1'b0, 1'b0);
        check(oe_any, 1'b1);
        repeat (10) @(posedge clock);
        check(stby, 1'b1);
        check(oe_n, 1'b1);
        for (int i = 0; i < 32; i++) begin
            seed = xorshift(seed);
            run(i[4], i[2:0], i[3], int'(seed[2:0]));
        end
        repeat (20) @(posedge clock);
        print_verdict();
    end
endmodule

`default_nettype wire
